// File: hdl/qmx_framer.sv
// Purpose: Four-tributary muldex framer: transmit framing and receive deframing.
// Assumes: ref_clk is the composite bit clock, one line bit per cycle.
// Notes: Tributaries are fed on request; receive output is valid only when locked.
`timescale 1ns/1ns
`default_nettype none
module qmx_framer
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Configuration
    input wire logic scr_enable,
    // Transmit tributaries
    input wire logic [3:0] trib_bit,
    input wire logic [3:0] trib_just_req,
    output logic [3:0] trib_take,
    // Transmit service bits, bit 0 is the local remote-alarm request
    input wire logic [3:0] tx_service,
    // Line
    output logic tx_line,
    output logic tx_frame_start,
    input wire logic rx_line,
    // Receive tributaries
    output logic [3:0] rx_trib_bit,
    output logic [3:0] rx_trib_valid,
    output logic [3:0] rx_justified,
    // Receive status, rx_service bit 0 is the far-end remote alarm
    output logic [3:0] rx_service,
    output logic rx_aligned,
    output logic rx_align_lost
);
    import qmx_pkg::*;

    qmx_slot_type tx_pos;
    qmx_slot_type rx_pos;

    // Transmit pipeline registers
    logic [3:0] just_r;
    logic p1_use_r;
    logic p1_fix_r;
    logic p1_key_r;
    logic p1_first_r;
    logic [1:0] p1_slot_r;
    logic [3:0] trib_take_r;
    logic tx_line_r;
    logic tx_frame_r;
    logic tx_use;
    logic tx_fix;
    logic tx_bit;

    // Receive registers
    logic rx_s1_r;
    logic rx_s2_r;
    logic [10:0] rx_sr_r;
    qmx_align_type al_r;
    qmx_align_type al_nxt;
    logic [1:0] miss_r;
    logic [1:0] miss_nxt;
    logic rx_load;
    logic rx_lost;
    logic [2:0] cnt_r [NUM_TRIBS];
    logic [3:0] rx_trib_bit_r;
    logic [3:0] rx_valid_r;
    logic [3:0] rx_just_r;
    logic [3:0] rx_svc_r;
    logic rx_aligned_r;
    logic rx_lost_r;
    logic locked;
    logic faw_hit;
    logic faw_check;
    logic rx_d;
    logic maj_now;
    logic rx_take;

    // Transmit timer: advances one line bit per cycle at the composite rate
    qmx_slot_timer u_tx_timer
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .scr_on(scr_enable),
        .load(1'b0),
        .pos(tx_pos)
    );

    // Receive timer, realigned on a candidate word
    qmx_slot_timer u_rx_timer
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .scr_on(scr_enable),
        .load(rx_load),
        .pos(rx_pos)
    );

    // Transmit stage 1 decode: payload slots pull from tributary slot order
    assign tx_use = tx_pos.data || (tx_pos.jpos && !just_r[tx_pos.slot]);
    assign tx_fix = tx_pos.faw ? tx_pos.faw_bit :
                    tx_pos.ctrl ? just_r[tx_pos.slot] :
                    tx_pos.serv ? tx_service[tx_pos.slot] :
                    1'b0;

    // Stage 2 composes the bit; the word itself is never keyed
    assign tx_bit = (p1_use_r ? trib_bit[p1_slot_r] : p1_fix_r) ^ p1_key_r;

    // Justification decision is held for the whole frame
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            just_r <= 4'h0;
        else if (tx_pos.first)
            just_r <= trib_just_req;
    end

    // Transmit stage 1: request the tributary bit one cycle ahead
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            p1_use_r <= 1'b0;
            p1_fix_r <= 1'b0;
            p1_key_r <= 1'b0;
            p1_first_r <= 1'b0;
            p1_slot_r <= 2'h0;
            trib_take_r <= 4'h0;
        end
        else
        begin
            p1_use_r <= tx_use;
            p1_fix_r <= tx_fix;
            p1_key_r <= tx_pos.key;
            p1_first_r <= tx_pos.first;
            p1_slot_r <= tx_pos.slot;
            trib_take_r <= tx_use ? 4'h1 << tx_pos.slot : 4'h0;
        end
    end

    // Transmit stage 2: line bit and frame marker
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            tx_line_r <= 1'b0;
            tx_frame_r <= 1'b0;
        end
        else
        begin
            tx_line_r <= tx_bit;
            tx_frame_r <= p1_first_r;
        end
    end

    // Line input is asynchronous to ref_clk: two flops before use
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rx_s1_r <= 1'b0;
            rx_s2_r <= 1'b0;
            rx_sr_r <= 11'h000;
        end
        else
        begin
            rx_s1_r <= rx_line;
            rx_s2_r <= rx_s1_r;
            rx_sr_r <= {rx_sr_r[9:0], rx_s2_r};
        end
    end

    // Word search window ends on the current bit
    assign faw_hit = {rx_sr_r, rx_s2_r} == FAW_WORD;
    assign faw_check = rx_pos.faw && rx_pos.bit_idx == FAW_LAST;
    assign locked = al_r == AL_LOCKED;
    assign rx_d = rx_s2_r ^ rx_pos.key;
    assign maj_now = cnt_r[rx_pos.slot] >= MAJ_THRESH;
    assign rx_take = locked && (rx_pos.data || (rx_pos.jpos && !maj_now));

    // Alignment state machine; misses only count at the predicted position
    always_comb
    begin
        al_nxt = al_r;
        miss_nxt = miss_r;
        rx_load = 1'b0;
        rx_lost = 1'b0;
        unique case (al_r)
            AL_SEARCH:
                if (faw_hit)
                begin
                    rx_load = 1'b1;
                    al_nxt = AL_CONF1;
                end
            AL_CONF1:
                if (faw_check)
                    al_nxt = faw_hit ? AL_CONF2 : AL_SEARCH;
            AL_CONF2:
                if (faw_check)
                    al_nxt = faw_hit ? AL_LOCKED : AL_SEARCH;
            AL_LOCKED:
                if (faw_check)
                begin
                    if (faw_hit)
                        miss_nxt = 2'h0;
                    else if (miss_r == MISS_LAST)
                    begin
                        al_nxt = AL_SEARCH;
                        miss_nxt = 2'h0;
                        rx_lost = 1'b1;
                    end
                    else
                        miss_nxt = miss_r + 2'h1;
                end
        endcase
    end

    // Alignment registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            al_r <= AL_SEARCH;
            miss_r <= 2'h0;
            rx_aligned_r <= 1'b0;
            rx_lost_r <= 1'b0;
        end
        else
        begin
            al_r <= al_nxt;
            miss_r <= miss_nxt;
            rx_aligned_r <= al_nxt == AL_LOCKED;
            rx_lost_r <= rx_lost;
        end
    end

    // Control-bit ones are counted per tributary, cleared each frame
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || rx_pos.first)
        begin
            for (int i = 0; i < NUM_TRIBS; i++)
                cnt_r[i] <= 3'h0;
        end
        else if (rx_pos.ctrl && rx_d)
            cnt_r[rx_pos.slot] <= cnt_r[rx_pos.slot] + 3'h1;
    end

    // Receive demultiplex; nothing is delivered while out of lock
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rx_trib_bit_r <= 4'h0;
            rx_valid_r <= 4'h0;
            rx_just_r <= 4'h0;
            rx_svc_r <= 4'h0;
        end
        else
        begin
            rx_valid_r <= rx_take ? 4'h1 << rx_pos.slot : 4'h0;
            if (rx_take)
                rx_trib_bit_r[rx_pos.slot] <= rx_d;
            if (locked && rx_pos.jpos)
                rx_just_r[rx_pos.slot] <= maj_now;
            if (locked && rx_pos.serv)
                rx_svc_r[rx_pos.slot] <= rx_d;
        end
    end

    // Outputs straight from flops
    assign trib_take = trib_take_r;
    assign tx_line = tx_line_r;
    assign tx_frame_start = tx_frame_r;
    assign rx_trib_bit = rx_trib_bit_r;
    assign rx_trib_valid = rx_valid_r;
    assign rx_justified = rx_just_r;
    assign rx_service = rx_svc_r;
    assign rx_aligned = rx_aligned_r;
    assign rx_align_lost = rx_lost_r;

    // Checking helpers: cycles between frame markers
    logic [11:0] gap_r;
    logic seen_r;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            gap_r <= 12'h000;
            seen_r <= 1'b0;
        end
        else
        begin
            gap_r <= tx_frame_r ? 12'h000 : gap_r + 12'h001;
            seen_r <= seen_r | tx_frame_r;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_word_on_line: assert property (tx_frame_start |-> tx_line ##1 tx_line ##1 tx_line
        ##1 tx_line ##1 tx_line ##1 !tx_line ##1 tx_line ##1 !tx_line [*5])
        else $error("alignment word wrong on line");

    chk_frame_length: assert property (
        tx_frame_start && seen_r |-> gap_r == 12'(FRAME_BITS - 1))
        else $error("frame length wrong");

    chk_ctrl_value: assert property (tx_pos.ctrl |=> !p1_use_r && p1_fix_r == just_r[p1_slot_r])
        else $error("control bit does not match justification");

    chk_take_order: assert property (p1_use_r |-> trib_take == 4'h1 << p1_slot_r)
        else $error("tributary request out of order");

    chk_alarm_sent: assert property (tx_pos.serv && tx_pos.slot == 2'h0
        |=> !p1_use_r && p1_fix_r == $past(tx_service[0]))
        else $error("remote alarm bit not sent");

    chk_loss_four: assert property (locked && faw_check && !faw_hit && miss_r == 2'h3
        |=> rx_align_lost && !rx_aligned && al_r == AL_SEARCH)
        else $error("alignment loss not declared");

    chk_recover_three: assert property ($rose(rx_aligned) |-> $past(al_r) == AL_CONF2)
        else $error("alignment declared too early");

    chk_candidate_drop: assert property ((al_r == AL_CONF1 || al_r == AL_CONF2)
        && faw_check && !faw_hit |=> al_r == AL_SEARCH && !rx_aligned)
        else $error("failed candidate not abandoned");

    chk_majority_vote: assert property (locked && rx_pos.jpos
        |=> rx_justified[$past(rx_pos.slot)] == $past(maj_now))
        else $error("justification vote wrong");

endmodule : qmx_framer
`default_nettype wire

// File: hdl/qmx_pkg.sv
// Purpose: Shared constants and types for the four-tributary line muldex framer.
// Assumes: One composite line bit per ref_clk cycle.
// Notes: Bit and set indices count from zero here; set 0 is the first set.
package qmx_pkg;

    // Composite and tributary rates, in kbit/s, and the rate tolerance
    localparam int LINE_RATE_KBPS = 564992;
    localparam int TRIB_RATE_KBPS = 139264;
    localparam int RATE_TOL_PPM = 15;

    // Frame geometry
    localparam int NUM_TRIBS = 4;
    localparam int FRAME_BITS = 2688;
    localparam logic [2:0] SET_LAST = 3'h6;
    localparam logic [8:0] SET_BIT_LAST = 9'h17f;
    localparam logic [8:0] FAW_LEN = 9'h00c;
    localparam logic [8:0] FAW_LAST = 9'h00b;
    localparam logic [8:0] CTRL_LEN = 9'h004;
    localparam logic [8:0] SERV_LEN = 9'h004;
    localparam logic [8:0] JUST_LO = 9'h004;
    localparam logic [8:0] JUST_HI = 9'h007;

    // Frame alignment word, first bit sent is the MSB
    localparam logic [11:0] FAW_WORD = 12'hfa0;

    // Scrambler states: preset at frame start, and the state at bit 12
    localparam logic [6:0] SCR_PRESET = 7'h7f;
    localparam logic [6:0] SCR_AT_DATA = 7'h0f;

    // Alignment and majority thresholds
    localparam int LOSS_COUNT = 4;
    localparam logic [1:0] MISS_LAST = 2'(LOSS_COUNT - 1);
    localparam logic [2:0] MAJ_THRESH = 3'h3;

    // Position of the current line bit within the frame
    typedef struct packed {
        logic [2:0] set_idx;
        logic [8:0] bit_idx;
        logic [1:0] slot;
        logic first;
        logic last;
        logic faw;
        logic ctrl;
        logic serv;
        logic jpos;
        logic data;
        logic faw_bit;
        logic key;
    } qmx_slot_type;

    // Receive alignment states
    typedef enum logic [1:0] {AL_SEARCH, AL_CONF1, AL_CONF2, AL_LOCKED} qmx_align_type;

endpackage : qmx_pkg

// File: hdl/qmx_slot_timer.sv
// Purpose: Frame position counter with the per-frame reset scrambler.
// Assumes: One line bit per cycle; four line bits make one tributary time.
// Notes: load jumps to set 0 bit 12, used by the receiver after a word hit.
`timescale 1ns/1ns
`default_nettype none
module qmx_slot_timer
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Control
    input wire logic scr_on,
    input wire logic load,
    // Position of the current bit
    output qmx_pkg::qmx_slot_type pos
);
    import qmx_pkg::*;

    logic [2:0] set_r;
    logic [8:0] bit_r;
    logic [6:0] scr_r;
    logic [6:0] scr_nxt;
    logic set_end;
    logic mid_set;
    logic step;
    logic scr_tap_stage0;
    logic scr_tap_stage2;
    logic scr_tap_stage5;
    logic scr_tap_stage6;
    logic tap;

    // Field decode of the current position
    assign set_end = bit_r == SET_BIT_LAST;
    assign mid_set = set_r != 3'h0 && set_r != SET_LAST;
    assign pos.set_idx = set_r;
    assign pos.bit_idx = bit_r;
    assign pos.slot = bit_r[1:0];
    assign pos.first = set_r == 3'h0 && bit_r == 9'h000;
    assign pos.last = set_r == SET_LAST && set_end;
    assign pos.faw = set_r == 3'h0 && bit_r < FAW_LEN;
    assign pos.ctrl = mid_set && bit_r < CTRL_LEN;
    assign pos.serv = set_r == SET_LAST && bit_r < SERV_LEN;
    assign pos.jpos = set_r == SET_LAST && bit_r >= JUST_LO && bit_r <= JUST_HI;
    assign pos.data = !(pos.faw || pos.ctrl || pos.serv || pos.jpos);

    // Stage taps; each tributary slot gets its own delayed sequence
    assign scr_tap_stage0 = scr_r[0];
    assign scr_tap_stage2 = scr_r[2];
    assign scr_tap_stage5 = scr_r[5];
    assign scr_tap_stage6 = scr_r[6];
    assign tap = bit_r[1] ? (bit_r[0] ? scr_tap_stage6 : scr_tap_stage5)
                          : (bit_r[0] ? scr_tap_stage2 : scr_tap_stage0);

    // Word comes from stages 5 and 6 right after preset, else the constant
    assign pos.faw_bit = scr_on ? (bit_r[0] ? scr_tap_stage6 : scr_tap_stage5)
                                : FAW_WORD[4'hb - bit_r[3:0]];
    assign pos.key = scr_on && !pos.faw && tap;

    // Shift toward stage 0, feedback into stage 6; one step per tributary time
    assign step = bit_r[1:0] == 2'h3;
    assign scr_nxt = {scr_r[0] ^ scr_r[1], scr_r[6:1]};

    // Position counter; a realign wins over the frame wrap, or a word hit that
    // lands on the last bit would put the candidate off by the word every frame
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            set_r <= 3'h0;
            bit_r <= 9'h000;
        end
        else if (load)
        begin
            set_r <= 3'h0;
            bit_r <= FAW_LEN;
        end
        else if (set_end)
        begin
            set_r <= pos.last ? 3'h0 : set_r + 3'h1; // Wraps after set 6
            bit_r <= 9'h000;
        end
        else
            bit_r <= bit_r + 9'h001;
    end

    // Reset scrambler: all ones at every frame start, no self-sync needed
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            scr_r <= SCR_PRESET;
        else if (load)
            scr_r <= SCR_AT_DATA;
        else if (pos.last)
            scr_r <= SCR_PRESET;
        else if (step)
            scr_r <= scr_nxt;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_scr_frame_preset: assert property (pos.last && !load |=> scr_r == 7'h7f)
        else $error("scrambler not preset at frame start");

    chk_scr_word_out: assert property (
        scr_on && pos.faw |-> pos.faw_bit == FAW_WORD[4'hb - bit_r[3:0]])
        else $error("scrambler did not produce alignment word");

endmodule : qmx_slot_timer
`default_nettype wire

// File: verif/qmx_remote_muldex.sv
// Purpose: Far-end line muldex model that loops the local line back with one bit of delay.
// Assumes: The near end frames are a faithful image of what a remote muldex would send.
// Notes: Faults are one inverted bit per frame, on command, at the word or a control bit.
`timescale 1ns/1ns
`default_nettype none
module qmx_remote_muldex
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Line from the near end
    input wire logic line_in,
    input wire logic frame_in,
    // Fault commands
    input wire logic kill_word,
    input wire logic flip_ctrl,
    // Line to the near end
    output logic line_out
);
    import qmx_pkg::*;

    logic [11:0] pos_r;
    logic [11:0] pos_nxt;
    logic line_r;

    // Frame position follows the near end's frame marker
    assign pos_nxt = frame_in ? 12'h000 : pos_r + 12'h001;
    assign line_out = line_r;

    // Echo the frame; a fault only ever touches one bit so the rest stays lawful
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            pos_r <= 12'h000;
            line_r <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            line_r <= line_in ^ (kill_word && pos_nxt == 12'h000)
                ^ (flip_ctrl && pos_nxt == 12'h180);
        end
    end
endmodule : qmx_remote_muldex
`default_nettype wire

// File: verif/quad_tributary_muldex_framer_tb.sv
// Purpose: Self-checking bench for the framer, looped back through the far-end model.
// Assumes: Constant tributary levels, so the scrambled line cannot imitate the word.
// Notes: Frames are captured at the rising edge, stimulus changes at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module quad_tributary_muldex_framer_tb;
    import qmx_pkg::*;

    localparam int LIMIT = 80000;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic scr_enable = 1'b0;
    logic kill = 1'b0;
    logic flip = 1'b0;
    logic [3:0] trib_bit = 4'hb;
    logic [3:0] trib_just_req = 4'h5;
    logic [3:0] tx_service = 4'h1;
    logic [3:0] trib_take, rx_trib_bit, rx_trib_valid, rx_justified, rx_service;
    logic tx_line, tx_frame_start, rx_line, rx_aligned, rx_align_lost;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int pos = 0;
    int rx_bad = 0;
    int tk [4];
    int rv [4];
    logic frm [0:FRAME_BITS-1];

    qmx_framer u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .scr_enable(scr_enable),
        .trib_bit(trib_bit), .trib_just_req(trib_just_req), .trib_take(trib_take),
        .tx_service(tx_service), .tx_line(tx_line), .tx_frame_start(tx_frame_start),
        .rx_line(rx_line), .rx_trib_bit(rx_trib_bit), .rx_trib_valid(rx_trib_valid),
        .rx_justified(rx_justified), .rx_service(rx_service), .rx_aligned(rx_aligned),
        .rx_align_lost(rx_align_lost));
    qmx_remote_muldex u_far (.ref_clk(ref_clk), .rst_b(rst_b), .line_in(tx_line),
        .frame_in(tx_frame_start), .kill_word(kill), .flip_ctrl(flip), .line_out(rx_line));

    // Clock at 50 MHz
    initial forever #10 ref_clk = ~ref_clk;

    // Capture the frame and count takes and deliveries per frame; edge values are pre-update
    always @(posedge ref_clk)
    begin
        cyc++;
        if (tx_frame_start === 1'b1)
        begin
            pos = 0;
            tk = '{default: 0};
            rv = '{default: 0};
        end
        else if (pos < FRAME_BITS - 1)
            pos++;
        frm[pos] = tx_line;
        for (int k = 0; k < 4; k++)
        begin
            if (trib_take[k] === 1'b1)
                tk[k]++;
            if (rx_trib_valid[k] === 1'b1)
            begin
                rv[k]++;
                if (rx_aligned === 1'b1 && rx_trib_bit[k] !== trib_bit[k])
                    rx_bad++;
            end
        end
        if (cyc == LIMIT)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait for the falling edge inside a frame-start cycle
    task automatic wait_start(output int n);
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (tx_frame_start !== 1'b1 && n < 3000);
    endtask : wait_start

    task automatic wait_frames(input int cnt);
        int n;
        repeat (cnt) wait_start(n);
    endtask : wait_frames

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
    endtask : do_reset

    function automatic logic [11:0] word_of();
        logic [11:0] w;
        for (int i = 0; i < 12; i++)
            w[11 - i] = frm[i];
        return w;
    endfunction : word_of

    function automatic logic [3:0] nib(input int at);
        return {frm[at + 3], frm[at + 2], frm[at + 1], frm[at]};
    endfunction : nib

    // Plain frame layout with scrambling off
    task automatic t_layout();
        int n;
        wait_frames(2);
        wait_start(n);
        chk("frame_len", 16'(FRAME_BITS), 16'(n));
        chk("word", 16'(FAW_WORD), 16'(word_of()));
        for (int s = 1; s < 6; s++)
            chk("ctrl", 16'(trib_just_req), 16'(nib(384 * s)));
        chk("service", 16'(tx_service), 16'(nib(2304)));
        chk("stuff", 16'(trib_bit & ~trib_just_req), 16'(nib(2308)));
        chk("data_set1", 16'(trib_bit), 16'(nib(12)));
        chk("data_set2", 16'(trib_bit), 16'(nib(388)));
        for (int k = 0; k < 4; k++)
            chk("take_count", 16'(663 - trib_just_req[k]), 16'(tk[k]));
    endtask : t_layout

    // Scrambler keys, per-frame reset, and lock after the third word
    task automatic t_lock();
        logic [3:0] key;
        key = {SCR_AT_DATA[6], SCR_AT_DATA[5], SCR_AT_DATA[2], SCR_AT_DATA[0]};
        wait_frames(2);
        chk("scr_word", 16'(FAW_WORD), 16'(word_of()));
        chk("scr_key1", 16'(trib_bit ^ key), 16'(nib(12)));
        chk("unlocked", 16'h0000, 16'(rx_aligned));
        wait_frames(1);
        chk("scr_key2", 16'(trib_bit ^ key), 16'(nib(12)));
        repeat (5) @(negedge ref_clk);
        chk("two_words", 16'h0000, 16'(rx_aligned));
        repeat (60) @(negedge ref_clk);
        chk("three_words", 16'h0001, 16'(rx_aligned));
    endtask : t_lock

    // Receive path with one control bit corrupted per frame
    task automatic t_rx();
        trib_bit = 4'hb;
        trib_just_req = 4'h5;
        tx_service = 4'h3;
        flip = 1'b1;
        wait_frames(2);
        rx_bad = 0;
        wait_frames(2);
        chk("majority", 16'(trib_just_req), 16'(rx_justified));
        chk("rx_service", 16'h0003, 16'(rx_service));
        chk("rx_data", 16'h0000, 16'(rx_bad));
        for (int k = 0; k < 4; k++)
            chk("rx_count", 16'(663 - trib_just_req[k]), 16'(rv[k]));
        flip = 1'b0;
    endtask : t_rx

    // Loss after four misses, then a candidate dropped by one miss
    task automatic t_loss();
        logic seen;
        kill = 1'b1;
        wait_frames(3);
        repeat (5) @(negedge ref_clk);
        chk("three_misses", 16'h0001, 16'(rx_aligned));
        seen = 1'b0;
        repeat (60)
        begin
            @(negedge ref_clk);
            seen = seen | (rx_align_lost === 1'b1);
        end
        chk("lost_pulse", 16'h0001, 16'(seen));
        chk("lost_level", 16'h0000, 16'(rx_aligned));
        kill = 1'b0;
        // The far end reads kill at the edge ending a frame-start cycle
        wait_frames(1);
        @(negedge ref_clk);
        kill = 1'b1;
        wait_frames(1);
        @(negedge ref_clk);
        kill = 1'b0;
        wait_frames(1);
        repeat (60) @(negedge ref_clk);
        chk("dropped", 16'h0000, 16'(rx_aligned));
        wait_frames(2);
        repeat (60) @(negedge ref_clk);
        chk("relocked", 16'h0001, 16'(rx_aligned));
    endtask : t_loss

    // Main sequence
    initial
    begin
        do_reset();
        t_layout();
        @(negedge ref_clk);
        scr_enable = 1'b1;
        trib_bit = 4'hf;
        trib_just_req = 4'h0;
        do_reset();
        t_lock();
        t_rx();
        t_loss();
        complete_run();
    end
endmodule : quad_tributary_muldex_framer_tb
`default_nettype wire
